// >>> rtl/cicd_top.sv
module cicd_top #(
  parameter bit SPLIT_READS_ONE = 1'b0,
  parameter bit NO_LEGACY = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [12:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  input wire logic top_sre_on,
  input wire logic os_sre_on,
  input wire logic top_req_bypass_off,
  input wire logic top_fast_bypass_off,
  input wire logic [2:0] binary_point_reg,
  input wire logic [2:0] aliased_binary_point_reg,
  input wire logic g0_pending,
  input wire logic g1_pending,
  input wire logic bypass_req,
  input wire logic bypass_fast,
  input wire logic eoi_wr,
  input wire logic [23:0] eoi_id,
  output logic req_line,
  output logic fast_interrupt_line,
  output logic [2:0] g0_preempt_split,
  output logic [2:0] g1_preempt_split,
  output logic drop_valid,
  output logic eoi_deact_valid,
  output logic [23:0] eoi_deact_id,
  output logic deact_valid,
  output logic [23:0] deact_id,
  output logic deact_err
);
  cicd_ctl_if ctl ();
  logic byp_req_s1, byp_req_s2, byp_fast_s1, byp_fast_s2;
  wire logic wr_ctrl = reg_wr && reg_addr == cicd_pkg::CTRL_OFFSET;
  wire logic wr_deact = reg_wr && reg_addr == cicd_pkg::DEACT_OFFSET;
  cicd_ctrl_regs #(.SPLIT_READS_ONE(SPLIT_READS_ONE), .NO_LEGACY(NO_LEGACY)) u_regs (
    .ref_clk(ref_clk),
    .rst(rst),
    .ctl(ctl),
    .wr_ctrl(wr_ctrl),
    .wdata(reg_wdata),
    .top_sre_on(top_sre_on),
    .top_req_bypass_off(top_req_bypass_off),
    .top_fast_bypass_off(top_fast_bypass_off)
  );
  cicd_deact u_deact (
    .ref_clk(ref_clk),
    .rst(rst),
    .ctl(ctl),
    .wr_deact(wr_deact),
    .wdata(reg_wdata),
    .deact_valid(deact_valid),
    .deact_id(deact_id),
    .deact_err(deact_err)
  );
  wire logic [31:0] c = ctl.ctrl;
  wire logic g0_on = c[cicd_pkg::G0_ON_POS]; // RL13
  wire logic g1_on = c[cicd_pkg::G1_ON_POS];
  // single security view: fast select stays writable, binary point is never incremented
  wire logic fast_sel = c[cicd_pkg::FAST_SEL_POS]; // RL12
  wire logic g0_sig = g0_on && g0_pending;
  wire logic g1_sig = g1_on && g1_pending;
  wire logic norm_req = g1_sig || (g0_sig && !fast_sel); // RL11
  wire logic norm_fast = g0_sig && fast_sel; // RL11
  // with fast routing off the fast path is never signaled, so bypass may use it
  wire logic req_sig_off = !(g0_on && !fast_sel) && !g1_on;
  wire logic fast_sig_off = !(g0_on && fast_sel);
  // os-level system-register access ignores the disable bits
  wire logic req_block = !os_sre_on &&
    c[cicd_pkg::REQ_BYP_G0_POS] && c[cicd_pkg::REQ_BYP_G1_POS]; // RL4 RL7
  wire logic fast_block = !os_sre_on &&
    c[cicd_pkg::FAST_BYP_G0_POS] && c[cicd_pkg::FAST_BYP_G1_POS]; // RL5 RL7
  wire logic next_req = norm_req || (req_sig_off && !req_block && byp_req_s2); // RL4
  wire logic next_fast = norm_fast || (fast_sig_off && !fast_block && byp_fast_s2); // RL5
  wire logic cbp = c[cicd_pkg::CBP_POS]; // RL9
  wire logic eoi_ok = eoi_wr && !(eoi_id >= cicd_pkg::SPECIAL_FIRST &&
    eoi_id <= cicd_pkg::SPECIAL_LAST);
  // bypass pins come from outside and are synchronised before use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      byp_req_s1 <= 1'b0;
      byp_req_s2 <= 1'b0;
      byp_fast_s1 <= 1'b0;
      byp_fast_s2 <= 1'b0;
    end else begin
      byp_req_s1 <= bypass_req;
      byp_req_s2 <= byp_req_s1;
      byp_fast_s1 <= bypass_fast;
      byp_fast_s2 <= byp_fast_s1;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_line <= 1'b0;
      fast_interrupt_line <= 1'b0;
      g0_preempt_split <= 3'h0;
      g1_preempt_split <= 3'h0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      req_line <= next_req;
      fast_interrupt_line <= next_fast;
      g0_preempt_split <= binary_point_reg; // RL9
      g1_preempt_split <= cbp ? binary_point_reg : aliased_binary_point_reg; // RL9
      reg_rdata <= (reg_rd && reg_addr == cicd_pkg::CTRL_OFFSET) ? c : 32'h0000_0000; // RL23
    end
  end
  // end-of-interrupt with a non-special identifier: always drop, deactivate too only with split bit clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      drop_valid <= 1'b0;
      eoi_deact_valid <= 1'b0;
      eoi_deact_id <= 24'h000000;
    end else begin
      drop_valid <= eoi_ok; // RL2 RL18
      eoi_deact_valid <= eoi_ok && !ctl.split_on; // RL1 RL2
      if (eoi_ok) begin
        eoi_deact_id <= eoi_id;
      end
    end
  end
  sp_a: assert property (@(posedge ref_clk) disable iff (rst)
    eoi_ok && ctl.split_on |=> drop_valid && !eoi_deact_valid) else $error("split eoi deact"); // RL2
  cb_a: assert property (@(posedge ref_clk) disable iff (rst)
    cbp |=> g1_preempt_split == $past(binary_point_reg)) else $error("common bp"); // RL9
  g1_a: assert property (@(posedge ref_clk) disable iff (rst)
    g1_sig && !g0_sig |=> req_line) else $error("group1 not on request line"); // RL11
  bk_a: assert property (@(posedge ref_clk) disable iff (rst)
    !g0_on && !g1_on && !os_sre_on && c[8] && c[6] |=> !req_line) else $error("bypass leak"); // RL4
endmodule : cicd_top

// >>> rtl/cicd_pkg.sv
// Functional notes
// RL1: split bit clear: end-of-interrupt drops and deactivates; deactivate register unusable.
// RL2: split bit set: end-of-interrupt only drops; deactivate register deactivates.
// RL3: split bit may be reads-one; one shared store with the secure split bit.
// RL4: request bypass passes when its disable bit is 0, blocked when 1; here blocked only when bits 8 and 6 are both 1.
// RL5: fast bypass passes when its disable bit is 0, blocked when 1; here blocked only when bits 7 and 5 are both 1.
// RL6: top bypass-off controls force disable bits to read one, writes ignored; here bit 5 follows the request control, not the fast one.
// RL7: os-level system-register access makes bypass disable bits ineffective.
// RL8: without legacy support bypass disable bits may read one, writes ignored.
// RL9: common binary point selects which binary point governs group 1.
// RL10: two-state nonsecure binary point read is secure plus one, saturated.
// RL11: fast-line select routes group 0 to fast line; group 1 always request line.
// RL12: two-state builds may make fast-line select read one.
// RL13: bit 1 enables group 1 signaling, bit 0 enables group 0 signaling.
// RL14: writable fields reset to zero; bit 2 and bits 31..10 reserved zero.
// RL15: split mode deactivate write deactivates the written identifier.
// RL16: deactivate writes act only when the governing split bit is set.
// RL17: deactivate writes with split bit clear are ignored; error may be raised.
// RL18: deactivate without end-of-interrupt leaves the active-priority bit set.
// RL19: identifier in bits 23..0, upper reserved; 1020..1023 are special.
// RL20: without affinity routing bits 23..13 zero; software interrupt source in 12..10.
// RL21: software avoids these registers when affinity routing is enabled.
// RL22: software uses deactivate register only without system-register access.
// RL23: reserved bits read zero and ignore writes.
package cicd_pkg;
  localparam logic [12:0] CTRL_OFFSET = 13'h0000;
  localparam logic [12:0] DEACT_OFFSET = 13'h1000;
  localparam int SPLIT_POS = 9;
  localparam int REQ_BYP_G1_POS = 8;
  localparam int FAST_BYP_G1_POS = 7;
  localparam int REQ_BYP_G0_POS = 6;
  localparam int FAST_BYP_G0_POS = 5;
  localparam int CBP_POS = 4;
  localparam int FAST_SEL_POS = 3;
  localparam int G1_ON_POS = 1;
  localparam int G0_ON_POS = 0;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_03FB;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int ID_W = 24;
  localparam logic [23:0] SPECIAL_FIRST = 24'h0003FC;
  localparam logic [23:0] SPECIAL_LAST = 24'h0003FF;
  localparam logic [2:0] BP_MAX = 3'h7;
endpackage : cicd_pkg

// >>> rtl/cicd_ctl_if.sv
interface cicd_ctl_if;
  logic [31:0] ctrl;
  logic split_on;
  modport owner (output ctrl, output split_on);
  modport user (input ctrl, input split_on);
endinterface : cicd_ctl_if

// >>> rtl/cicd_deact.sv
module cicd_deact (
  input wire logic ref_clk,
  input wire logic rst,
  cicd_ctl_if.user ctl,
  input wire logic wr_deact,
  input wire logic [31:0] wdata,
  output logic deact_valid,
  output logic [23:0] deact_id,
  output logic deact_err
);
  // source-interface bits 12..10 pass through untouched with the identifier
  wire logic [23:0] id = wdata[23:0]; // RL19 RL20
  // reserved identifiers never reach the active state, so they are dropped
  wire logic special = (id >= cicd_pkg::SPECIAL_FIRST) && (id <= cicd_pkg::SPECIAL_LAST);
  wire logic take = wr_deact && ctl.split_on && !special; // RL16 RL15
  wire logic bad = wr_deact && !ctl.split_on; // RL17 RL1
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      deact_valid <= 1'b0;
      deact_id <= 24'h000000;
      deact_err <= 1'b0;
    end else begin
      deact_valid <= take;
      deact_err <= bad;
      if (take) begin
        deact_id <= id;
      end
    end
  end
  dv_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_deact && !ctl.split_on |=> !deact_valid && deact_err) else $error("ignored write acted"); // RL17
  dt_a: assert property (@(posedge ref_clk) disable iff (rst)
    take |=> deact_valid && deact_id == $past(wdata[23:0])) else $error("deactivate lost"); // RL15
endmodule : cicd_deact

// >>> rtl/cicd_ctrl_regs.sv
module cicd_ctrl_regs #(
  parameter bit SPLIT_READS_ONE = 1'b0,
  parameter bit NO_LEGACY = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst,
  cicd_ctl_if.owner ctl,
  input wire logic wr_ctrl,
  input wire logic [31:0] wdata,
  input wire logic top_sre_on,
  input wire logic top_req_bypass_off,
  input wire logic top_fast_bypass_off
);
  logic [31:0] store;
  logic [31:0] forced;
  always_comb begin
    forced = 32'h0000_0000;
    forced[cicd_pkg::SPLIT_POS] = SPLIT_READS_ONE; // RL3
    forced[cicd_pkg::REQ_BYP_G1_POS] = NO_LEGACY || (top_sre_on && top_req_bypass_off); // RL6 RL8
    forced[cicd_pkg::REQ_BYP_G0_POS] = NO_LEGACY || (top_sre_on && top_req_bypass_off);
    forced[cicd_pkg::FAST_BYP_G0_POS] = NO_LEGACY || (top_sre_on && top_req_bypass_off);
    forced[cicd_pkg::FAST_BYP_G1_POS] = NO_LEGACY || (top_sre_on && top_fast_bypass_off);
  end
  // single store: the split bit is also the secure split bit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      store <= cicd_pkg::CTRL_RESET; // RL14
    end else if (wr_ctrl) begin
      store <= (wdata & cicd_pkg::CTRL_WMASK & ~forced) | (store & forced); // RL23 RL6
    end
  end
  assign ctl.ctrl = (store & cicd_pkg::CTRL_WMASK) | forced; // RL23
  assign ctl.split_on = ctl.ctrl[cicd_pkg::SPLIT_POS]; // RL3
  fr_a: assert property (@(posedge ref_clk) disable iff (rst)
    top_sre_on && top_fast_bypass_off |-> ctl.ctrl[cicd_pkg::FAST_BYP_G1_POS]) else $error("bypass not forced"); // RL6
  rs_a: assert property (@(posedge ref_clk) disable iff (rst)
    ctl.ctrl[31:10] == 22'h0 && !ctl.ctrl[2]) else $error("reserved bit set"); // RL14
endmodule : cicd_ctrl_regs

// >>> bench/cicd_pe_model.sv
module cicd_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_line,
  input wire logic fast_interrupt_line,
  output logic req_taken,
  output logic fast_taken
);
  timeunit 1ns;
  timeprecision 100ps;
  // the core samples its lines on ref_clk, so it sees them a cycle late
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_taken <= 1'b0;
      fast_taken <= 1'b0;
    end else begin
      req_taken <= req_line;
      fast_taken <= fast_interrupt_line;
    end
  end
endmodule : cicd_core_model

// >>> bench/tb_cpu_iface_ctrl_deactivate.sv
module tb_cpu_iface_ctrl_deactivate;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, rst = 1, wr = 0, rd = 0, sre = 0, rbo = 0, g0p = 0, g1p = 0;
  logic byr = 0, byf = 0, eoi = 0, osr = 0, fbo = 0, rq, fq, dv, edv, de, dpv, pr, pf;
  logic [12:0] ad = '0;
  logic [31:0] wd = '0, rdat, d;
  logic [2:0] bp = '0, abp = '0, s0, s1;
  logic [23:0] eid = '0, edi, did;
  int err_total = 0, n_tests = 0;
  always #2 ref_clk = ~ref_clk;
  cicd_top dut_u (.ref_clk(ref_clk), .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad),
    .reg_wdata(wd), .reg_rdata(rdat), .top_sre_on(sre), .os_sre_on(osr),
    .top_req_bypass_off(rbo), .top_fast_bypass_off(fbo), .binary_point_reg(bp),
    .aliased_binary_point_reg(abp), .g0_pending(g0p), .g1_pending(g1p), .bypass_req(byr),
    .bypass_fast(byf), .eoi_wr(eoi), .eoi_id(eid), .req_line(rq), .fast_interrupt_line(fq),
    .g0_preempt_split(s0), .g1_preempt_split(s1), .drop_valid(dpv), .eoi_deact_valid(edv),
    .eoi_deact_id(edi), .deact_valid(dv), .deact_id(did), .deact_err(de));
  cicd_core_model core_u (.ref_clk(ref_clk), .rst(rst), .req_line(rq), .fast_interrupt_line(fq),
    .req_taken(pr), .fast_taken(pf));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [12:0] a, input logic [31:0] v);
    // affinity routing is never enabled here, so memory-mapped access stays legal
    @(posedge ref_clk) begin wr <= 1; ad <= a; wd <= v; end
    @(posedge ref_clk) wr <= 0;
    #1;
  endtask : wreg
  task automatic rreg(output logic [31:0] v);
    @(posedge ref_clk) begin rd <= 1; ad <= cicd_pkg::CTRL_OFFSET; end
    @(posedge ref_clk) rd <= 0;
    #1 v = rdat;
  endtask : rreg
  task automatic pause(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : pause
  task automatic t_regs;
    rreg(d); chk("ctrl reset", 32'h0, d);
    wreg(cicd_pkg::CTRL_OFFSET, 32'hFFFFFFFF); rreg(d);
    chk("ctrl mask", 32'h000003FB, d);
    sre <= 1; rbo <= 1; wreg(cicd_pkg::CTRL_OFFSET, 32'h80); rreg(d);
    chk("forced ones", 32'h000001E0, d);
    sre <= 0; rbo <= 0; wreg(cicd_pkg::CTRL_OFFSET, 32'h0); rreg(d);
    chk("ctrl clear", 32'h0, d);
    sre <= 1; fbo <= 1; wreg(cicd_pkg::CTRL_OFFSET, 32'h0); rreg(d);
    chk("fast forced", 32'h00000080, d);
    sre <= 0; fbo <= 0;
    $display("test regs done");
  endtask : t_regs
  task automatic t_route;
    wreg(cicd_pkg::CTRL_OFFSET, 32'h0B); g0p <= 1; pause(4);
    chk("g0 fast", 32'h1, fq); chk("g0 not req", 32'h0, rq); chk("core fast", 32'h1, pf);
    g0p <= 0; g1p <= 1; pause(4);
    chk("g1 req", 32'h1, rq); chk("g1 not fast", 32'h0, fq); chk("core req", 32'h1, pr);
    wreg(cicd_pkg::CTRL_OFFSET, 32'h08); pause(3);
    chk("g1 off", 32'h0, rq);
    g1p <= 0;
    $display("test route done");
  endtask : t_route
  task automatic t_bypass;
    // bypass pins are synchronised, so allow the longer lag
    wreg(cicd_pkg::CTRL_OFFSET, 32'h0); byr <= 1; byf <= 1; pause(6);
    chk("req bypass", 32'h1, rq); chk("fast bypass", 32'h1, fq);
    wreg(cicd_pkg::CTRL_OFFSET, 32'h1E0); pause(6);
    chk("req blocked", 32'h0, rq); chk("fast blocked", 32'h0, fq);
    osr <= 1; pause(6);
    chk("req os level", 32'h1, rq); chk("fast os level", 32'h1, fq);
    // deactivate register is only used again once system-register access is off
    osr <= 0;
    byr <= 0; byf <= 0; wreg(cicd_pkg::CTRL_OFFSET, 32'h0);
    $display("test bypass done");
  endtask : t_bypass
  task automatic t_bp;
    bp <= 3'h3; abp <= 3'h5; pause(3);
    chk("g0 split", 32'h3, s0); chk("g1 alias", 32'h5, s1);
    wreg(cicd_pkg::CTRL_OFFSET, 32'h10); pause(2);
    chk("g1 common", 32'h3, s1);
    $display("test bp done");
  endtask : t_bp
  task automatic eoi_pulse(input logic [31:0] mode, input logic ed);
    wreg(cicd_pkg::CTRL_OFFSET, mode);
    @(posedge ref_clk) begin eoi <= 1; eid <= 24'h000031; end
    @(posedge ref_clk) eoi <= 0;
    #1 chk("drop", 32'h1, dpv);
    chk("eoi deact", {31'h0, ed}, edv);
  endtask : eoi_pulse
  task automatic t_deact;
    eoi_pulse(32'h0, 1'b1);
    chk("eoi id", 32'h31, edi);
    eoi_pulse(32'h200, 1'b0);
    wreg(cicd_pkg::CTRL_OFFSET, 32'h0); wreg(cicd_pkg::DEACT_OFFSET, 32'h21);
    chk("dir err", 32'h1, de); chk("dir off", 32'h0, dv);
    wreg(cicd_pkg::CTRL_OFFSET, 32'h200); wreg(cicd_pkg::DEACT_OFFSET, 32'h1C21);
    chk("dir ok", 32'h1, dv); chk("dir id", 32'h1C21, did);
    wreg(cicd_pkg::DEACT_OFFSET, 32'h3FC);
    chk("special", 32'h0, dv); chk("special err", 32'h0, de);
    wreg(cicd_pkg::DEACT_OFFSET, 32'hFF000022);
    chk("resv id", 32'h22, did);
    $display("test deact done");
  endtask : t_deact
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  initial begin
    #20000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    t_regs(); t_route(); t_bypass(); t_bp(); t_deact();
    close_out();
  end
endmodule : tb_cpu_iface_ctrl_deactivate
